//--- bit_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  // clock of the receiving domain
  input wire logic clk,
  // level from the other domain
  input wire logic [WIDTH-1:0] d,
  // synchronised level
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_t;

  sync_t r;
  sync_t next_r;

  // first stage feeds only the second
  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign q = r.s2;

endmodule : bit_sync

//--- burst_cfg_defs.svh
// constants for the burst read configuration block
`ifndef BURST_CFG_DEFS_SVH
`define BURST_CFG_DEFS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ADDR_CFG 8'h00
`define ADDR_STATUS 8'h04
`define CFG_RESET 16'h8000
`define CFG_WMASK 16'hbbcf
`define STATUS_PAD 30'h0000_0000
`define CFG_PAD 16'h0000
`define RDATA_ZERO 32'h0000_0000

// ----------------------------------------------------------------
// burst shaping
// ----------------------------------------------------------------
`define LAT_CODE_BIAS 4'h2
`define BL_4 3'h1
`define BL_8 3'h2
`define BL_CONT 3'h7
`define ALIGN_8 3'h0
`define ADDR_STEP 19'h0_0001
`define CNT_ZERO 4'h0
`define CNT_STEP 4'h1

`endif

//--- burst_cfg_pkg.sv
// shared types for the burst read configuration block
package burst_cfg_pkg;

  // ----------------------------------------------------------------
  // configuration word layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic read_mode_select;
    logic reserved_bit_14;
    logic [2:0] initial_latency_field;
    logic reserved_bit_10;
    logic inter_word_delay_bit;
    logic ready_timing_bit;
    logic address_order_bit;
    logic active_edge_select;
    logic [1:0] reserved_bits_5_4;
    logic wrap_disable_bit;
    logic [2:0] burst_count_field;
  } cfg_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_LATENCY = 2'b01,
    PH_DATA = 2'b10,
    PH_STALL = 2'b11
  } phase_t;

  // ----------------------------------------------------------------
  // state groups
  // ----------------------------------------------------------------
  typedef struct packed {
    phase_t phase;
    logic [3:0] cnt;
    logic [3:0] beats;
    logic ygap;
    logic unaligned;
    logic [18:0] start;
    logic [18:0] addr;
  } burst_t;

  typedef struct packed {
    logic [18:0] addr;
    logic ready;
    logic word_change;
  } link_out_t;

  typedef struct packed {
    cfg_t cfg;
    logic cfg_toggle;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } bus_state_t;

  typedef struct packed {
    cfg_t cfg;
    logic toggle_seen;
    burst_t burst;
    link_out_t out;
  } link_state_t;

endpackage : burst_cfg_pkg

//--- burst_read_config_decode.sv
// burst configuration register, apb slave and synchronous burst sequencer
`timescale 1ns/1ps
`include "burst_cfg_defs.svh"
module burst_read_config_decode (
  // system clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // burst link, driven by the host on the burst clock
  input wire logic link_clk,
  input wire logic burst_select,
  input wire logic burst_latch,
  input wire logic [18:0] burst_start_addr,
  input wire logic burst_advance_n,
  // burst link outputs
  output logic [18:0] burst_addr,
  output logic data_ready,
  output logic word_change
);

  // ----------------------------------------------------------------
  // bus side state
  // ----------------------------------------------------------------
  burst_cfg_pkg::bus_state_t r;
  burst_cfg_pkg::bus_state_t next_r;
  logic [1:0] back_sync;
  logic busy_m;
  logic cfg_pending;

  assign busy_m = back_sync[0];
  assign cfg_pending = back_sync[1] != r.cfg_toggle;

  // apb decode, one cycle setup then zero-wait access
  always_comb begin
    next_r = r;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    if (psel && !penable) begin
      next_r.pready = 1'b1;
      next_r.prdata = `RDATA_ZERO;
      next_r.pslverr = (paddr != `ADDR_CFG) && (paddr != `ADDR_STATUS);
      if (!pwrite && paddr == `ADDR_CFG) begin
        next_r.prdata = {`CFG_PAD, r.cfg};
      end else if (!pwrite && paddr == `ADDR_STATUS) begin
        next_r.prdata = {`STATUS_PAD, cfg_pending, busy_m};
      end
    end
    if (psel && penable && r.pready && pwrite && paddr == `ADDR_CFG) begin
      next_r.cfg = pwdata[15:0] & `CFG_WMASK;
      next_r.cfg_toggle = ~r.cfg_toggle;
    end
    if (!rst_n) begin
      next_r.cfg = `CFG_RESET;
      next_r.cfg_toggle = 1'b0;
      next_r.pready = 1'b0;
      next_r.pslverr = 1'b0;
      next_r.prdata = `RDATA_ZERO;
    end
  end

  always_ff @(posedge mclk) begin
    r <= next_r;
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;

  // ----------------------------------------------------------------
  // clocking of the link side
  // ----------------------------------------------------------------
  logic edge_rise;
  logic act_clk;
  logic [1:0] fwd_sync;
  logic link_rst_n;
  logic toggle_l;

  // edge select crosses on the raw burst clock before it steers the mux
  bit_sync #(.WIDTH(1)) u_edge_sync (
    .clk(link_clk),
    .d(r.cfg.active_edge_select),
    .q(edge_rise)
  );

  edge_clock_select u_edge (
    .link_clk(link_clk),
    .rising_sel(edge_rise),
    .active_clk(act_clk)
  );

  // reset and configuration toggle into the link domain
  bit_sync #(.WIDTH(2)) u_fwd_sync (
    .clk(act_clk),
    .d({rst_n, r.cfg_toggle}),
    .q(fwd_sync)
  );

  assign link_rst_n = fwd_sync[1];
  assign toggle_l = fwd_sync[0];

  // ----------------------------------------------------------------
  // burst sequencing
  // ----------------------------------------------------------------
  burst_cfg_pkg::link_state_t l;
  burst_cfg_pkg::link_state_t next_l;
  burst_cfg_pkg::burst_t n1;
  burst_cfg_pkg::burst_t n2;

  // word address of beat b inside a wrapping burst
  function automatic logic [18:0] wrap_addr(input logic [18:0] st, input logic [3:0] b,
                                            input burst_cfg_pkg::cfg_t c);
    logic [2:0] lo;
    lo = 3'h0;
    if (c.address_order_bit) begin
      lo = st[2:0] + b[2:0];
    end else begin
      lo = st[2:0] ^ b[2:0];
    end
    if (c.burst_count_field == `BL_8) begin
      wrap_addr = {st[18:3], lo};
    end else begin
      wrap_addr = {st[18:3], st[2], lo[1:0]};
    end
  endfunction : wrap_addr

  // one active edge of the sequencer
  function automatic burst_cfg_pkg::burst_t step(input burst_cfg_pkg::burst_t s,
                                                 input burst_cfg_pkg::cfg_t c,
                                                 input logic sel, input logic latch,
                                                 input logic [18:0] saddr,
                                                 input logic adv_n);
    burst_cfg_pkg::burst_t n;
    logic nowrap;
    logic [18:0] inc;
    n = s;
    nowrap = c.wrap_disable_bit || (c.burst_count_field == `BL_CONT);
    inc = s.addr + `ADDR_STEP;
    unique case (s.phase)
      burst_cfg_pkg::PH_IDLE: begin
        if (sel && latch && !c.read_mode_select) begin
          n.phase = burst_cfg_pkg::PH_LATENCY;
          n.cnt = {1'b0, c.initial_latency_field};
          n.beats = `CNT_ZERO;
          n.ygap = 1'b0;
          n.start = saddr;
          n.unaligned = saddr[2:0] != `ALIGN_8;
        end
      end
      burst_cfg_pkg::PH_LATENCY: begin
        if (s.cnt == `CNT_ZERO) begin
          n.phase = burst_cfg_pkg::PH_DATA;
          n.addr = s.start;
        end else begin
          n.cnt = s.cnt - `CNT_STEP;
        end
      end
      burst_cfg_pkg::PH_DATA: begin
        if (!adv_n) begin
          if (c.inter_word_delay_bit && !s.ygap) begin
            n.ygap = 1'b1;
          end else begin
            n.ygap = 1'b0;
            n.beats = s.beats + `CNT_STEP;
            if (!nowrap) begin
              n.addr = wrap_addr(s.start, s.beats + `CNT_STEP, c);
            end else if (s.unaligned && inc[2:0] == `ALIGN_8) begin
              n.phase = burst_cfg_pkg::PH_STALL;
              n.unaligned = 1'b0;
            end else begin
              n.addr = inc;
            end
          end
        end
      end
      burst_cfg_pkg::PH_STALL: begin
        n.phase = burst_cfg_pkg::PH_DATA;
        n.addr = inc;
      end
    endcase
    if (!sel) begin
      n.phase = burst_cfg_pkg::PH_IDLE;
    end
    step = n;
  endfunction : step

  // edges on which the data bus carries no valid word
  function automatic logic invalid(input burst_cfg_pkg::burst_t s);
    invalid = (s.phase == burst_cfg_pkg::PH_LATENCY) || (s.phase == burst_cfg_pkg::PH_STALL);
  endfunction : invalid

  // n2 looks one edge further, assuming the host keeps the burst going
  always_comb begin
    n1 = step(l.burst, l.cfg, burst_select, burst_latch, burst_start_addr, burst_advance_n);
    n2 = step(n1, l.cfg, 1'b1, 1'b0, burst_start_addr, 1'b0);
  end

  // link state update, configuration taken only between bursts
  always_comb begin
    next_l = l;
    next_l.burst = n1;
    next_l.out.addr = n1.addr;
    next_l.out.word_change = (n1.phase == burst_cfg_pkg::PH_DATA) &&
                             ((l.burst.phase != burst_cfg_pkg::PH_DATA) ||
                              (n1.addr != l.burst.addr));
    if (l.cfg.ready_timing_bit) begin
      next_l.out.ready = !(invalid(n1) || invalid(n2));
    end else begin
      next_l.out.ready = !invalid(n1);
    end
    if (l.burst.phase == burst_cfg_pkg::PH_IDLE && toggle_l != l.toggle_seen) begin
      next_l.cfg = r.cfg;
      next_l.toggle_seen = toggle_l;
      next_l.burst.phase = burst_cfg_pkg::PH_IDLE;
      next_l.out.ready = 1'b1;
      next_l.out.word_change = 1'b0;
    end
    if (!link_rst_n) begin
      next_l.cfg = `CFG_RESET;
      next_l.toggle_seen = 1'b0;
      next_l.burst = '0;
      next_l.out.addr = '0;
      next_l.out.ready = 1'b1;
      next_l.out.word_change = 1'b0;
    end
  end

  always_ff @(posedge act_clk) begin
    l <= next_l;
  end

  assign burst_addr = l.out.addr;
  assign data_ready = l.out.ready;
  assign word_change = l.out.word_change;

  // busy and applied toggle back to the bus side
  bit_sync #(.WIDTH(2)) u_back_sync (
    .clk(mclk),
    .d({l.toggle_seen, l.burst.phase != burst_cfg_pkg::PH_IDLE}),
    .q(back_sync)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_async_holds_idle;
    @(posedge act_clk) disable iff (!link_rst_n)
    (l.cfg.read_mode_select && l.burst.phase == burst_cfg_pkg::PH_IDLE)
      |=> l.burst.phase == burst_cfg_pkg::PH_IDLE;
  endproperty
  a_async_holds_idle: assert property (p_async_holds_idle)
    else $error("burst started in asynchronous mode");

  property p_latency_load;
    @(posedge act_clk) disable iff (!link_rst_n)
    (l.burst.phase == burst_cfg_pkg::PH_IDLE && burst_select && burst_latch &&
     !l.cfg.read_mode_select && toggle_l == l.toggle_seen)
      |=> (l.burst.phase == burst_cfg_pkg::PH_LATENCY) &&
          (l.burst.cnt == {1'b0, $past(l.cfg.initial_latency_field)});
  endproperty
  a_latency_load: assert property (p_latency_load)
    else $error("latency count not loaded from its code");

  property p_latency_end;
    @(posedge act_clk) disable iff (!link_rst_n)
    (l.burst.phase == burst_cfg_pkg::PH_LATENCY && l.burst.cnt == `CNT_ZERO && burst_select)
      |=> (l.burst.phase == burst_cfg_pkg::PH_DATA) && (l.burst.addr == l.burst.start);
  endproperty
  a_latency_end: assert property (p_latency_end)
    else $error("first word not presented after latency");

  property p_word_each_cycle;
    @(posedge act_clk) disable iff (!link_rst_n)
    (l.burst.phase == burst_cfg_pkg::PH_DATA && !l.cfg.inter_word_delay_bit &&
     !burst_advance_n && burst_select)
      |=> (l.burst.beats == $past(l.burst.beats) + `CNT_STEP);
  endproperty
  a_word_each_cycle: assert property (p_word_each_cycle)
    else $error("word not advanced every cycle");

  property p_word_every_second;
    @(posedge act_clk) disable iff (!link_rst_n)
    (l.burst.phase == burst_cfg_pkg::PH_DATA && l.cfg.inter_word_delay_bit &&
     !l.burst.ygap && burst_select)
      |=> $stable(l.burst.addr) && $stable(l.burst.beats);
  endproperty
  a_word_every_second: assert property (p_word_every_second)
    else $error("word changed on the gap cycle");

  property p_ready_same_edge;
    @(posedge act_clk) disable iff (!link_rst_n)
    (!l.cfg.ready_timing_bit && (l.burst.phase == burst_cfg_pkg::PH_LATENCY ||
                                 l.burst.phase == burst_cfg_pkg::PH_STALL))
      |-> !data_ready;
  endproperty
  a_ready_same_edge: assert property (p_ready_same_edge)
    else $error("ready high while data invalid");

  property p_ready_early;
    @(posedge act_clk) disable iff (!link_rst_n)
    (l.cfg.ready_timing_bit && l.burst.phase == burst_cfg_pkg::PH_DATA)
      ##1 (l.burst.phase == burst_cfg_pkg::PH_STALL) |-> !$past(data_ready);
  endproperty
  a_ready_early: assert property (p_ready_early)
    else $error("ready not dropped a cycle early");

  property p_wrap_inside;
    @(posedge act_clk) disable iff (!link_rst_n)
    (l.burst.phase == burst_cfg_pkg::PH_DATA && !l.cfg.wrap_disable_bit &&
     l.cfg.burst_count_field == `BL_4)
      |-> l.burst.addr[18:2] == l.burst.start[18:2];
  endproperty
  a_wrap_inside: assert property (p_wrap_inside)
    else $error("wrapping burst left its boundary");

  property p_interleave;
    @(posedge act_clk) disable iff (!link_rst_n)
    (l.burst.phase == burst_cfg_pkg::PH_DATA && !l.cfg.address_order_bit &&
     !l.cfg.wrap_disable_bit && l.cfg.burst_count_field == `BL_8)
      |-> l.burst.addr[2:0] == (l.burst.start[2:0] ^ l.burst.beats[2:0]);
  endproperty
  a_interleave: assert property (p_interleave)
    else $error("interleaved order broken");

endmodule : burst_read_config_decode

//--- edge_clock_select.sv
// picks the active edge of the burst clock
`timescale 1ns/1ps
module edge_clock_select (
  // burst clock from the host
  input wire logic link_clk,
  // high selects the rising edge
  input wire logic rising_sel,
  // clock whose rising edge is the active edge
  output logic active_clk
);

  // select follows the configuration register through u_edge_sync, also while a burst is running
  always_comb begin
    if (rising_sel) begin
      active_clk = link_clk;
    end else begin
      active_clk = ~link_clk;
    end
  end

endmodule : edge_clock_select

//--- host_link_model.sv
// host side of the burst link: burst clock, latch, select and advance
`timescale 1ns/1ps
module host_link_model (
  // burst link towards the device
  output logic link_clk,
  output logic burst_select,
  output logic burst_latch,
  output logic [18:0] burst_start_addr,
  output logic burst_advance_n,
  input wire logic word_change,
  // control from the bench
  input wire logic run,
  input wire logic go,
  input wire logic rise,
  input wire logic slow,
  input wire logic [18:0] sa,
  input wire logic [4:0] nwords,
  output logic done
);
  logic k = 1'b0;
  logic busy = 1'b0;
  int n;

  assign link_clk = k;

  // ----------------------------------------------------------------
  // burst clock, still while neither the bench nor a burst needs it
  // ----------------------------------------------------------------
  always begin
    #32;
    if (run || busy) k = ~k;
  end

  // host drives on the edge opposite the active one
  task automatic drv();
    if (rise) @(negedge k);
    else @(posedge k);
  endtask : drv

  // one burst: idle edges, latch, count words, end with select low
  initial begin
    burst_select = 1'b0;
    burst_latch = 1'b0;
    burst_start_addr = 19'h0_0000;
    burst_advance_n = 1'b1;
    done = 1'b0;
    forever begin
      wait (go);
      busy = 1'b1;
      repeat (slow ? 6 : 2) drv();
      burst_select = 1'b1;
      burst_latch = 1'b1;
      burst_start_addr = sa;
      burst_advance_n = 1'b0;
      drv();
      burst_latch = 1'b0;
      // released address lines carry the inverse of the last value
      burst_start_addr = ~sa;
      n = 0;
      while (n < nwords) begin
        drv();
        if (word_change === 1'b1) n++;
      end
      burst_select = 1'b0;
      burst_advance_n = 1'b1;
      repeat (2) drv();
      busy = 1'b0;
      done = 1'b1;
      wait (!go);
      done = 1'b0;
    end
  end
endmodule : host_link_model

//--- tb_top.sv
// self-checking bench for the burst configuration block
`timescale 1ns/1ps
`include "burst_cfg_defs.svh"
module tb_top;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, chk_now;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [32:0] apb_q[$];
  logic link_clk, burst_select, burst_latch, burst_advance_n, data_ready, word_change;
  logic [18:0] burst_start_addr, burst_addr, sa;
  logic run, go, rise, slow, done, nowrap, seq, gap, first;
  logic [2:0] code, lenc;
  logic [4:0] nw;
  logic [15:0] cfg;
  logic [24:0] word_q[$];
  logic [24:0] word_e;
  int bad_count, cmp_count, lat, wgap, lcnt, js;
  int seed = 32'hddf62e34;

  burst_read_config_decode i_burst_read_config_decode (.mclk(mclk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
    .burst_select(burst_select), .burst_latch(burst_latch),
    .burst_start_addr(burst_start_addr), .burst_advance_n(burst_advance_n),
    .burst_addr(burst_addr), .data_ready(data_ready), .word_change(word_change));

  host_link_model i_host_link_model (.link_clk(link_clk), .burst_select(burst_select),
    .burst_latch(burst_latch), .burst_start_addr(burst_start_addr),
    .burst_advance_n(burst_advance_n), .word_change(word_change), .run(run), .go(go),
    .rise(rise), .slow(slow), .sa(sa), .nwords(nw), .done(done));

  // ----------------------------------------------------------------
  // comparison and verdict
  // ----------------------------------------------------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // apb master; the expected read result is noted for the monitor
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic c, input logic [32:0] e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    chk_now <= c;
    if (c) apb_q.push_back(e);
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [18:0] exp_addr(input logic [18:0] s, input int j);
    logic [18:0] m;
    m = (lenc == `BL_4) ? 19'h0_0003 : 19'h0_0007;
    if (nowrap) return s + 19'(j);
    if (seq) return (s & ~m) | ((s + 19'(j)) & m);
    return (s & ~m) | ((s ^ 19'(j)) & m);
  endfunction : exp_addr

  // apb monitor: takes the noted result at the completing edge
  always @(posedge mclk)
    if (psel && penable && pready === 1'b1 && chk_now && apb_q.size() > 0)
      chk({pslverr, prdata}, apb_q.pop_front());

  // link monitor at the active edge: latency, spacing, ready and address
  always @(link_clk) if (link_clk === rise && rst_n) begin
    if (burst_select && burst_latch) begin
      lcnt = 0;
      first = 1'b1;
    end else begin
      lcnt++;
      if (first && lcnt == 2) chk({32'h0, data_ready}, 33'h0);
      if (word_change === 1'b1 && word_q.size() > 0) begin
        word_e = word_q.pop_front();
        chk(33'(lcnt), 33'(word_e[23:19]));
        chk({14'h0, burst_addr}, {14'h0, word_e[18:0]});
        chk({32'h0, data_ready}, {32'h0, word_e[24]});
        lcnt = 0;
        first = 1'b0;
      end
    end
  end

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    #500000;
    bad_count++;
    conclude();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, chk_now, go, slow, rise, first} = '0;
    {paddr, pwdata, sa, nw} = '0;
    {nowrap, seq, gap, code, lenc, cfg, lcnt} = '0;
    run = 1'b1;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge link_clk);
    apb(0, `ADDR_CFG, 0, 1, {17'h0, `CFG_RESET});
    apb(0, 8'h08, 0, 1, {1'b1, 32'h0});
    apb(1, 8'h0c, 32'($random(seed)), 1, {1'b1, 32'h0});
    apb(1, `ADDR_CFG, 32'h0000_ffff, 0, 0);
    apb(0, `ADDR_CFG, 0, 1, {17'h0, `CFG_WMASK});
    for (int i = 0; i < 6; i++) begin
      code = 3'(2 + (i % 5));
      nowrap = (i == 5);
      lenc = nowrap ? `BL_CONT : (i[0] ? `BL_4 : `BL_8);
      gap = (i == 4);
      rise = i[0];
      seq = i[1] | nowrap;
      slow = i[2];
      // continuous burst starts off an 8-word boundary with early ready: one stall at word js
      cfg = {2'b00, code, 1'b0, gap, seq, seq, rise, 2'b00, nowrap, lenc};
      sa = 19'($random(seed));
      if (nowrap) sa[0] = 1'b1;
      js = nowrap ? 8 - sa[2:0] : 99;
      nw = nowrap ? 5'd10 : ((lenc == `BL_4) ? 5'd6 : 5'd10);
      lat = code + 2;
      wgap = gap ? 2 : 1;
      // note per word: ready, edges since the previous word, address
      for (int j = 0; j < nw; j++)
        word_q.push_back({!(seq && j + 1 == js), 5'(j == 0 ? lat : wgap + (j == js)),
                          exp_addr(sa, j)});
      run = 1'b1;
      apb(1, `ADDR_CFG, {16'h0, cfg}, 0, 0);
      apb(0, `ADDR_CFG, 0, 1, {17'h0, cfg});
      repeat (40) begin
        apb(0, `ADDR_STATUS, 0, 0, 0);
        if (rd[1] === 1'b0) break;
      end
      go = 1'b1;
      wait (done);
      go = 1'b0;
      chk(33'(word_q.size()), 33'h0);
      word_q.delete();
      run = 1'b0;
      #200;
    end
    chk(33'(apb_q.size()), 33'h0);
    conclude();
  end
endmodule : tb_top
